// ==== testbench/pid_plant_model.sv ====
// feedback transducer model, prompt or slowly settling
`timescale 1ns/1ns
`default_nettype none
module pid_plant_model (
  input  wire logic        clk_sys_in,
  input  wire logic        slow_in,
  input  wire logic [15:0] target_one_in,
  input  wire logic [15:0] target_two_in,
  output logic [15:0]      fb_one_out,
  output logic [15:0]      fb_two_out
);
  // a sluggish sensor moves one code per cycle toward the process value
  function automatic logic [15:0] step(input logic [15:0] c, t);
    return (c < t) ? c + 16'h0001 : (c > t) ? c - 16'h0001 : c;
  endfunction : step
  always_ff @(posedge clk_sys_in) begin
    fb_one_out <= slow_in ? step(fb_one_out, target_one_in) : target_one_in;
    fb_two_out <= slow_in ? step(fb_two_out, target_two_in) : target_two_in;
  end
endmodule : pid_plant_model
`default_nettype wire

// ==== testbench/process_pid_speed_regulator_bench.sv ====
// self-checking bench for the pid speed regulator
`timescale 1ns/1ns
`default_nettype none
`include "pid_speed_regs.svh"
module process_pid_speed_regulator_bench;
  import pid_speed_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        reset_in   = 1'b1;
  apb_req_t    req        = '0;
  logic        sleep_req  = 1'b0;
  logic        slow       = 1'b0;
  logic [15:0] tgt_one    = '0;
  logic [15:0] tgt_two    = '0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, drive_on_out, pid_valid_out;
  logic [15:0] freq_ref_out, fb_one, fb_two, sp, er, f0;
  logic [32:0] notes[$];
  logic [32:0] nt;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          seed = 32'h6b3ff73a;
  always #50 clk_sys_in = ~clk_sys_in;
  pid_speed_regulator #(.TICK_COUNT(4)) pid_speed_regulator_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(req.psel),
    .penable_in(req.penable), .pwrite_in(req.pwrite),
    .paddr_in(req.paddr), .pwdata_in(req.pwdata),
    .analog_input_one_in(fb_one), .analog_input_two_in(fb_two),
    .sleep_request_in(sleep_req), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .freq_ref_out(freq_ref_out), .drive_on_out(drive_on_out),
    .pid_valid_out(pid_valid_out));
  pid_plant_model pid_plant_model_inst (
    .clk_sys_in(clk_sys_in), .slow_in(slow), .target_one_in(tgt_one),
    .target_two_in(tgt_two), .fb_one_out(fb_one), .fb_two_out(fb_two));
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // each finished transfer is judged against the oldest note
  always @(posedge clk_sys_in) begin
    if (req.psel && req.penable && pready_out === 1'b1) begin
      nt = notes.pop_front();
      chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr_out});
      if (!req.pwrite) chk("prdata", nt[31:0], prdata_out);
    end
  end
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, input logic [32:0] e);
    notes.push_back(e);
    @(posedge clk_sys_in);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_sys_in);
    req.penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    req <= '0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    xfer(a, 1'b1, {16'h0, d}, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    xfer(a, 1'b0, 32'h0, e);
  endtask : rd
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tk
  task automatic fr(input string nm, input logic [15:0] e);
    chk(nm, {16'h0, e}, {16'h0, freq_ref_out});
  endtask : fr
  task automatic dr(input logic e);
    chk("drive_on", {31'h0, e}, {31'h0, drive_on_out});
  endtask : dr
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  initial begin
    tk(20000);
    n_mismatch++;
    results();
  end
  initial begin
    tk(12);
    reset_in <= 1'b0;
    rd(`REG_GAIN_P, {17'h0, `RST_GAIN_P});
    rd(`REG_TIME_I, {17'h0, `RST_TIME_I});
    rd(`REG_FB_SEL, 33'h1);
    rd(12'hffc, {1'b1, 32'h0});
    xfer(12'hffc, 1'b1, 32'h5, {1'b1, 32'h0});
    rd(`REG_STATUS, 33'h0);
    fr("freq idle", 16'h0);
    // integral off so the output is the plain proportional term
    wr(`REG_TIME_I, 16'h0);
    wr(`REG_GAIN_P, 16'h100);
    wr(`REG_SRC_SEL, 16'h4);
    wr(`REG_MODE, 16'h1);
    tk(3);
    chk("valid", 32'h0, {31'h0, pid_valid_out});
    wr(`REG_SRC_SEL, 16'h5);
    tk(3);
    chk("valid", 32'h1, {31'h0, pid_valid_out});
    for (int i = 0; i < 4; i++) begin
      sp = 16'h4000 + 16'($random(seed) & 32'hfff);
      er = 16'h0010 + 16'($random(seed) & 32'hff);
      tgt_one <= sp - er;
      tgt_two <= 16'($random(seed));
      wr(`REG_SETPOINT, sp);
      rd(`REG_SETPOINT, {17'h0, sp});
      wr(`REG_MODE, 16'h1);
      tk(12);
      fr("p term", er);
      wr(`REG_GAIN_P, 16'h200);
      tk(12);
      fr("double gain", er << 1);
      wr(`REG_MODE, 16'h3);
      tk(12);
      fr("negative", 16'h0);
      wr(`REG_GAIN_P, 16'h100);
    end
    tgt_two <= sp;
    wr(`REG_MODE, 16'h1);
    wr(`REG_FB_SEL, 16'h2);
    tk(12);
    fr("input two", 16'h0);
    tgt_one <= sp;
    wr(`REG_FREQ_CMD, 16'h123);
    wr(`REG_MODE, 16'h9);
    tk(12);
    fr("added cmd", 16'h123);
    wr(`REG_FB_SEL, 16'h1);
    tgt_one <= sp - er;
    wr(`REG_MODE, 16'h1);
    wr(`REG_TIME_I, 16'h2);
    tk(8);
    f0 = freq_ref_out;
    tk(16);
    chk("integral", 32'h1, {31'h0, freq_ref_out > f0});
    wr(`REG_MODE, 16'h0);
    tgt_one <= sp;
    tk(12);
    fr("disabled", 16'h0);
    wr(`REG_MODE, 16'h1);
    tk(6);
    fr("integral cleared", 16'h0);
    // sleep countdown with one interruption
    wr(`REG_TIME_I, 16'h0);
    tgt_one <= sp - 16'h200;
    wr(`REG_SLEEP_LVL, 16'h100);
    wr(`REG_SLEEP_DLY, 16'h3);
    wr(`REG_WAKE_LVL, 16'h80);
    wr(`REG_WAKE_DLY, 16'h2);
    wr(`REG_SLEEP_SEL, 16'h1);
    tk(4);
    tgt_one <= sp;
    tk(8);
    tgt_one <= sp - 16'h200;
    tk(4);
    tgt_one <= sp;
    // a timer that only paused would already be asleep here
    tk(16);
    dr(1'b1);
    tk(8);
    dr(1'b0);
    fr("asleep", 16'h0);
    rd(`REG_STATUS, 33'h7);
    tgt_one <= sp - 16'h180;
    tk(6);
    dr(1'b0);
    tk(14);
    dr(1'b1);
    // a lagging sensor must not matter to the digital request
    slow <= 1'b1;
    wr(`REG_SLEEP_SEL, 16'h2);
    sleep_req <= 1'b1;
    tk(8);
    dr(1'b0);
    sleep_req <= 1'b0;
    tk(8);
    dr(1'b1);
    wr(`REG_SLEEP_SEL, 16'h0);
    wr(`REG_GAIN_D, 16'h100);
    wr(`REG_MODE, 16'h5);
    tgt_one <= sp;
    tk(600);
    dr(1'b1);
    fr("derivative settled", 16'h0);
    // reset again in mid run
    reset_in <= 1'b1;
    tk(2);
    dr(1'b0);
    fr("reset", 16'h0);
    reset_in <= 1'b0;
    rd(`REG_GAIN_D, 33'h0);
    rd(`REG_MODE, 33'h0);
    results();
  end
endmodule : process_pid_speed_regulator_bench
`default_nettype wire

// ==== verilog/delay_timer.sv ====
// qualifying timer: done once cond holds for limit plus one ticks
`timescale 1ns/1ns
`default_nettype none
module delay_timer (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        tick_in,
  input  wire logic        cond_in,
  input  wire logic [15:0] limit_in,
  output logic             done_out
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !cond_in) begin
      cnt_q    <= 16'h0;
      done_out <= 1'b0;
    end else if (tick_in) begin
      if (cnt_q >= limit_in) begin
        done_out <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h1;
      end
    end
  end
  a_timer_restart: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) !cond_in |=> (cnt_q == 16'h0 && !done_out))
    else $error("delay timer kept count after condition dropped");
endmodule : delay_timer
`default_nettype wire

// ==== verilog/pid_speed_pkg.sv ====
// types for the process pid speed regulator
package pid_speed_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef enum logic [1:0] {
    st_off   = 2'b00,
    st_run   = 2'b01,
    st_sleep = 2'b11
  } run_state_t;
endpackage : pid_speed_pkg

// ==== verilog/pid_speed_regs.svh ====
// constants and function list for the process pid speed regulator
`ifndef PID_SPEED_REGS_SVH
`define PID_SPEED_REGS_SVH
`define REG_MODE        12'h000
`define REG_SETPOINT    12'h004
`define REG_GAIN_P      12'h008
`define REG_TIME_I      12'h00c
`define REG_GAIN_D      12'h010
`define REG_FB_SEL      12'h014
`define REG_SRC_SEL     12'h018
`define REG_SLEEP_SEL   12'h01c
`define REG_SLEEP_LVL   12'h020
`define REG_SLEEP_DLY   12'h024
`define REG_WAKE_LVL    12'h028
`define REG_WAKE_DLY    12'h02c
`define REG_FREQ_CMD    12'h030
`define REG_STATUS      12'h034
`define REG_OUT         12'h038
`define MODE_EN_BIT     0
`define MODE_NEG_BIT    1
`define MODE_DFB_BIT    2
`define MODE_ADD_BIT    3
`define FB_SEL_ONE      2'd1
`define FB_SEL_TWO      2'd2
`define SRC_SEL_PID     4'd5
`define SLEEP_OFF       2'd0
`define SLEEP_LEVEL     2'd1
`define SLEEP_INPUT     2'd2
`define RST_GAIN_P      16'h0200
`define RST_TIME_I      16'h0032
`define TICK_NS         1000000
`define CLK_NS          100
`define TICK_CYCLES     (`TICK_NS / `CLK_NS)
`endif

// ==== verilog/pid_speed_regulator.sv ====
// pid regulator top with apb registers, sleep control and tick
`timescale 1ns/1ns
`default_nettype none
`include "pid_speed_regs.svh"
module pid_speed_regulator
  import pid_speed_pkg::*;
#(
  parameter int unsigned TICK_COUNT = `TICK_CYCLES,
  parameter int unsigned I_SCALE    = 8
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [15:0] analog_input_one_in,
  input  wire logic [15:0] analog_input_two_in,
  input  wire logic        sleep_request_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [15:0]      freq_ref_out,
  output logic             drive_on_out,
  output logic             pid_valid_out
);
  apb_req_t req;
  assign req = '{paddr: paddr_in, psel: psel_in, penable: penable_in,
                 pwrite: pwrite_in, pwdata: pwdata_in};

  logic [3:0]  mode_q;
  logic [15:0] setpoint_q;
  logic [15:0] gain_p_q;
  logic [15:0] time_i_q;
  logic [15:0] gain_d_q;
  logic [1:0]  fb_sel_q;
  logic [3:0]  src_sel_q;
  logic [1:0]  sleep_sel_q;
  logic [15:0] sleep_lvl_q;
  logic [15:0] sleep_dly_q;
  logic [15:0] wake_lvl_q;
  logic [15:0] wake_dly_q;
  logic [15:0] freq_cmd_q;

  logic        tick;
  logic        sleep_done;
  logic        wake_done;
  run_state_t  state_q;
  logic        mapped;
  logic        wr_fire;

  // one word per register; unmapped answers slverr
  always_comb begin
    unique case (req.paddr)
      `REG_MODE, `REG_SETPOINT, `REG_GAIN_P, `REG_TIME_I, `REG_GAIN_D,
      `REG_FB_SEL, `REG_SRC_SEL, `REG_SLEEP_SEL, `REG_SLEEP_LVL,
      `REG_SLEEP_DLY, `REG_WAKE_LVL, `REG_WAKE_DLY, `REG_FREQ_CMD,
      `REG_STATUS, `REG_OUT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // single wait state: pready rises the cycle after penable
  assign wr_fire = req.psel && req.penable && pready_out && req.pwrite;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end else if (req.psel && req.penable && !pready_out) begin
      pready_out  <= 1'b1;
      pslverr_out <= !mapped;
      prdata_out  <= 32'h0;
      if (!req.pwrite) begin
        unique case (req.paddr)
          `REG_MODE:      prdata_out <= {28'h0, mode_q};
          `REG_SETPOINT:  prdata_out <= {16'h0, setpoint_q};
          `REG_GAIN_P:    prdata_out <= {16'h0, gain_p_q};
          `REG_TIME_I:    prdata_out <= {16'h0, time_i_q};
          `REG_GAIN_D:    prdata_out <= {16'h0, gain_d_q};
          `REG_FB_SEL:    prdata_out <= {30'h0, fb_sel_q};
          `REG_SRC_SEL:   prdata_out <= {28'h0, src_sel_q};
          `REG_SLEEP_SEL: prdata_out <= {30'h0, sleep_sel_q};
          `REG_SLEEP_LVL: prdata_out <= {16'h0, sleep_lvl_q};
          `REG_SLEEP_DLY: prdata_out <= {16'h0, sleep_dly_q};
          `REG_WAKE_LVL:  prdata_out <= {16'h0, wake_lvl_q};
          `REG_WAKE_DLY:  prdata_out <= {16'h0, wake_dly_q};
          `REG_FREQ_CMD:  prdata_out <= {16'h0, freq_cmd_q};
          `REG_STATUS:    prdata_out <= {29'h0, pid_valid_out,
                                         state_q};
          `REG_OUT:       prdata_out <= {16'h0, freq_ref_out};
          default:        prdata_out <= 32'h0;
        endcase
      end
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mode_q      <= 4'h0;
      setpoint_q  <= 16'h0;
      gain_p_q    <= `RST_GAIN_P;
      time_i_q    <= `RST_TIME_I;
      gain_d_q    <= 16'h0;
      fb_sel_q    <= `FB_SEL_ONE;
      src_sel_q   <= 4'h0;
      sleep_sel_q <= `SLEEP_OFF;
      sleep_lvl_q <= 16'h0;
      sleep_dly_q <= 16'h0;
      wake_lvl_q  <= 16'h0;
      wake_dly_q  <= 16'h0;
      freq_cmd_q  <= 16'h0;
    end else if (wr_fire) begin
      unique case (req.paddr)
        `REG_MODE:      mode_q      <= req.pwdata[3:0];
        `REG_SETPOINT:  setpoint_q  <= req.pwdata[15:0];
        `REG_GAIN_P:    gain_p_q    <= req.pwdata[15:0];
        `REG_TIME_I:    time_i_q    <= req.pwdata[15:0];
        `REG_GAIN_D:    gain_d_q    <= req.pwdata[15:0];
        `REG_FB_SEL:    fb_sel_q    <= req.pwdata[1:0];
        `REG_SRC_SEL:   src_sel_q   <= req.pwdata[3:0];
        `REG_SLEEP_SEL: sleep_sel_q <= req.pwdata[1:0];
        `REG_SLEEP_LVL: sleep_lvl_q <= req.pwdata[15:0];
        `REG_SLEEP_DLY: sleep_dly_q <= req.pwdata[15:0];
        `REG_WAKE_LVL:  wake_lvl_q  <= req.pwdata[15:0];
        `REG_WAKE_DLY:  wake_dly_q  <= req.pwdata[15:0];
        `REG_FREQ_CMD:  freq_cmd_q  <= req.pwdata[15:0];
        default: ;
      endcase
    end
  end

  tick_divider #(.COUNT(TICK_COUNT)) u_tick (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .tick_out   (tick)
  );

  // datapath: values unsigned 16 bit, gains 8.8 fixed point
  logic               enable;
  logic               pid_used;
  logic [15:0]        fb;
  logic signed [17:0] err;
  logic signed [17:0] d_in;
  logic signed [17:0] d_prev_q;
  logic signed [35:0] p_term;
  logic signed [35:0] d_term;
  logic signed [35:0] integ_q;
  logic signed [35:0] step;
  logic signed [35:0] sum;
  logic signed [35:0] pid_out;
  logic signed [35:0] ref_sum;
  logic [15:0]        pid_sat_q;
  logic [15:0]        ref_d;

  assign enable = mode_q[`MODE_EN_BIT];
  // regulator only drives the reference when selected as source
  assign pid_used = (src_sel_q == `SRC_SEL_PID);
  assign fb = (fb_sel_q == `FB_SEL_TWO) ? analog_input_two_in
                                        : analog_input_one_in;
  assign err = mode_q[`MODE_NEG_BIT]
             ? 18'(signed'({2'b00, fb}) - signed'({2'b00, setpoint_q}))
             : 18'(signed'({2'b00, setpoint_q}) - signed'({2'b00, fb}));
  assign d_in = mode_q[`MODE_DFB_BIT] ? signed'({2'b00, fb}) : err;
  // proportional term
  // widen before the product, an 18 bit product overflows at gain 2.0
  assign p_term = (36'(err) * 36'(signed'({2'b00, gain_p_q}))) >>> 8;
  assign d_term = ((36'(d_in) - 36'(d_prev_q))
                   * 36'(signed'({2'b00, gain_d_q}))) >>> 8;
  // longer integral time gives smaller step
  assign step = (time_i_q == 16'h0) ? 36'sh0
              : 36'(p_term / signed'({21'h0, time_i_q}));
  assign sum  = p_term + integ_q + d_term;
  // sign of err already reflects the direction
  assign pid_out = sum;
  assign ref_sum = mode_q[`MODE_ADD_BIT]
                 ? pid_out + signed'({20'h0, freq_cmd_q}) : pid_out;

  always_comb begin
    if (ref_sum < 36'sh0) begin
      ref_d = 16'h0;
    end else if (ref_sum > 36'sh0ffff) begin
      ref_d = 16'hffff;
    end else begin
      ref_d = ref_sum[15:0];
    end
  end

  // integral held at zero when disabled
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !enable) begin
      integ_q  <= 36'sh0;
      d_prev_q <= 18'sh0;
    end else if (tick) begin
      integ_q  <= integ_q + step;
      d_prev_q <= d_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pid_sat_q <= 16'h0;
    end else if (tick) begin
      pid_sat_q <= enable ? ref_d : 16'h0;
    end
  end

  delay_timer u_sleep (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .tick_in    (tick),
    .cond_in    (state_q == st_run && pid_sat_q < sleep_lvl_q),
    .limit_in   (sleep_dly_q),
    .done_out   (sleep_done)
  );
  delay_timer u_wake (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .tick_in    (tick),
    .cond_in    (state_q == st_sleep && pid_sat_q > wake_lvl_q),
    .limit_in   (wake_dly_q),
    .done_out   (wake_done)
  );

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= st_off;
    end else begin
      unique case (state_q)
        st_off:   if (enable && pid_used) state_q <= st_run;
        st_run: begin
          if (!enable || !pid_used) begin
            state_q <= st_off;
          end else if ((sleep_sel_q == `SLEEP_LEVEL && sleep_done) ||
                       (sleep_sel_q == `SLEEP_INPUT &&
                        sleep_request_in)) begin
            state_q <= st_sleep;
          end
        end
        st_sleep: begin
          if (!enable || !pid_used || sleep_sel_q == `SLEEP_OFF) begin
            state_q <= st_off;
          end else if ((sleep_sel_q == `SLEEP_LEVEL && wake_done) ||
                       (sleep_sel_q == `SLEEP_INPUT &&
                        !sleep_request_in)) begin
            state_q <= st_run;
          end
        end
        default: state_q <= st_off;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      freq_ref_out  <= 16'h0;
      drive_on_out  <= 1'b0;
      pid_valid_out <= 1'b0;
    end else begin
      freq_ref_out  <= (state_q == st_run) ? pid_sat_q : 16'h0;
      drive_on_out  <= (state_q == st_run);
      pid_valid_out <= enable && pid_used;
    end
  end

  a_disable_zero: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) !enable |=> ##1 (freq_ref_out == 16'h0))
    else $error("reference nonzero while regulator disabled");
  a_integ_clear: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) !enable |=> (integ_q == 36'sh0))
    else $error("integral not cleared when disabled");
  a_sleep_off: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (state_q == st_sleep) |=> !drive_on_out)
    else $error("drive on while asleep");
  a_sleep_zero_sel: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (state_q == st_run && sleep_sel_q == `SLEEP_OFF)
    |=> (state_q != st_sleep))
    else $error("sleep entered with sleep disabled");
  a_source_needed: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) !pid_used |=> ##1 !drive_on_out)
    else $error("drive on without regulator source");
  a_fb_select: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (fb_sel_q == `FB_SEL_TWO &&
    !mode_q[`MODE_NEG_BIT]) |-> (err == 18'({2'b00, setpoint_q} -
    {2'b00, analog_input_two_in})))
    else $error("feedback source wrong");
  a_error_sign: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (!mode_q[`MODE_NEG_BIT] && fb < setpoint_q)
    |-> (err > 0))
    else $error("error sign wrong in positive mode");
  a_neg_sign: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (mode_q[`MODE_NEG_BIT] && fb < setpoint_q)
    |-> (err < 0))
    else $error("error sign wrong in negative mode");
  a_deriv_src: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (enable && mode_q[`MODE_DFB_BIT] && tick)
    |=> (d_prev_q == signed'({2'b00, $past(fb)})))
    else $error("derivative input not taken from feedback");
  a_apb_ready: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (psel_in && penable_in && !pready_out) |=> pready_out)
    else $error("apb answer late");
endmodule : pid_speed_regulator
`default_nettype wire

// ==== verilog/tick_divider.sv ====
// control tick divider producing a one cycle enable
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int unsigned COUNT = 10000
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  output logic      tick_out
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_q    <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_q == 32'(COUNT - 1)) begin
      cnt_q    <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule : tick_divider
`default_nettype wire
